/* rtl/sfcf_defs.svh */
// Constants of the serial flash command-frame decoder: opcodes, field layout, timing.
// Assumes it is included by its bare name from the top module.
`ifndef SFCF_DEFS_SVH
`define SFCF_DEFS_SVH

// ****************************************************************
// Frame layout
// ****************************************************************
`define SFCF_OPC_BITS 8
`define SFCF_ADDR_BYTES 3
`define SFCF_RSVD_BITS 4
`define SFCF_PAGE_BITS 11
`define SFCF_BYTE_BITS 9
`define SFCF_PAGE_MSB 19
`define SFCF_PAGE_LSB 9
`define SFCF_BYTE_MSB 8

// ****************************************************************
// Opcodes with special handling
// ****************************************************************
`define SFCF_OPC_RMW_A 8'h58
`define SFCF_OPC_RMW_B 8'h59
`define SFCF_OPC_DUMMY4 8'hD2
`define SFCF_OPC_DUMMY1_A 8'hD4
`define SFCF_OPC_DUMMY1_B 8'hD6
`define SFCF_DUMMY4_CNT 3'h4
`define SFCF_DUMMY1_CNT 3'h1

// ****************************************************************
// Timing
// ****************************************************************
`define SFCF_CLK_MHZ 100
`define SFCF_PUW_MS 3
`define SFCF_PUW_CYCLES (`SFCF_PUW_MS * 1000 * `SFCF_CLK_MHZ)
`define SFCF_VCSL_US 70
`define SFCF_VCSL_CYCLES (`SFCF_VCSL_US * `SFCF_CLK_MHZ)

`endif

/* rtl/sfcf_pkg.sv */
// Types shared by the serial flash command-frame decoder.
// Assumes sfcf_defs.svh is on the include path.
package sfcf_pkg;

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  typedef enum logic [1:0] {
    SFCF_LNK_OPC = 2'b00,
    SFCF_LNK_ADDR = 2'b01,
    SFCF_LNK_DUMMY = 2'b10,
    SFCF_LNK_DATA = 2'b11
  } sfcf_lnk_state_t;

  typedef enum logic [1:0] {
    SFCF_PWR_RESET = 2'b00,
    SFCF_PWR_STANDBY = 2'b01,
    SFCF_PWR_ACTIVE = 2'b10
  } sfcf_pwr_state_t;

  typedef enum logic [2:0] {
    SFCF_ACLS_NONE = 3'b000,
    SFCF_ACLS_PAGE_BYTE = 3'b001,
    SFCF_ACLS_PAGE = 3'b010,
    SFCF_ACLS_PAGE_HI = 3'b011,
    SFCF_ACLS_BYTE = 3'b100,
    SFCF_ACLS_DUMMY = 3'b101
  } sfcf_addr_cls_t;

  // ****************************************************************
  // Decoded command
  // ****************************************************************
  typedef struct packed {
    logic [7:0] opcode;
    sfcf_addr_cls_t addr_cls;
    logic [10:0] page_addr_bit;
    logic [8:0] byte_addr;
    logic rmw;
    logic [2:0] dummy_bytes;
  } sfcf_cmd_t;

endpackage : sfcf_pkg

/* rtl/sfcf_top.sv */
// Command-frame decoder and power-up state of a serial flash, 264-byte page mode.
// Assumes the host drives select, serial clock and serial input; the serial clock
// may stop between frames and is used as the clock of the link-side logic.
//
// Notes on behaviour
// RULE1 - A 24-bit address holds 4 reserved bits, 11 page bits from the top, then 9 byte bits.
// RULE2 - Each address bit is a page bit, a byte bit or a dummy bit depending on the opcode.
// RULE3 - Opcodes 58h and 59h mark a read-modify-write of the page, with page and byte fields.
// RULE4 - D2h is followed by four dummy bytes, D4h and D6h by one, others by none.
// RULE5 - A frame is an 8-bit opcode, then three address bytes, dummy bytes, data, MSB first.
// RULE6 - After power-up or reset the serial data output is high-impedance.
// RULE7 - An instruction is taken only after a falling edge of select following reset.
// RULE8 - Each falling edge of select samples the idle clock level to pick mode 0 or 3.
// RULE9 - The host waits at least 70 us after power-on before a read.
// RULE10 - While the power-on reset is active every command is ignored.
// RULE11 - The host starts no program or erase before the power-up delay of up to 3 ms ends.
// RULE12 - When the power-up delay ends the device goes to standby or active by select.
`timescale 1ns/100ps
`include "sfcf_defs.svh"

module sfcf_top #(
  parameter int PUW_CYCLES = `SFCF_PUW_CYCLES
) (
  // System clock and power-on reset.
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Serial link from the host.
  input wire logic spi_sck_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_si_i,
  // Serial data output pin.
  output logic spi_so_o,
  output logic spi_so_oe_o,
  // Decoded commands and state.
  output logic cmd_valid_o,
  output sfcf_pkg::sfcf_cmd_t cmd_o,
  output logic spi_mode3_o,
  output sfcf_pkg::sfcf_pwr_state_t pwr_state_o
);

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  if (PUW_CYCLES < 1 || PUW_CYCLES > 24'hFFFFFF) begin : g_bad_puw
    $error("PUW_CYCLES must lie between 1 and 2**24-1");
  end

  // ****************************************************************
  // Opcode classification
  // ****************************************************************
  function automatic sfcf_pkg::sfcf_addr_cls_t sfcf_cls(input logic [7:0] opc);
    sfcf_pkg::sfcf_addr_cls_t cls;
    cls = sfcf_pkg::SFCF_ACLS_NONE;
    case (opc)
      8'h01, 8'h02, 8'h03, 8'h0B, 8'h1B, 8'h58, 8'h59, 8'h82, 8'h85, 8'hD2: begin
        cls = sfcf_pkg::SFCF_ACLS_PAGE_BYTE; // RULE2
      end
      8'h53, 8'h55, 8'h60, 8'h61, 8'h81, 8'h83, 8'h86, 8'h88, 8'h89: begin
        cls = sfcf_pkg::SFCF_ACLS_PAGE;
      end
      8'h50, 8'h7C: cls = sfcf_pkg::SFCF_ACLS_PAGE_HI;
      8'h84, 8'h87, 8'hD1, 8'hD3, 8'hD4, 8'hD6: cls = sfcf_pkg::SFCF_ACLS_BYTE;
      8'h32, 8'h35, 8'h77: cls = sfcf_pkg::SFCF_ACLS_DUMMY;
      default: cls = sfcf_pkg::SFCF_ACLS_NONE;
    endcase
    return cls;
  endfunction : sfcf_cls

  // ****************************************************************
  // Link domain: frame shifter on the serial clock
  // ****************************************************************
  // Select high clears the frame, so a frame that stops mid-byte never leaks into the next.
  wire logic lnk_rst_n = reset_n_i & ~spi_cs_n_i;

  sfcf_pkg::sfcf_lnk_state_t lnk_state_q, lnk_state_d;
  logic [2:0] bit_cnt_q;
  logic [1:0] byte_cnt_q, byte_cnt_d;
  logic [2:0] dum_cnt_q, dum_cnt_d;
  logic [7:0] shift_q;
  logic [7:0] opc_q, opc_d;
  logic [23:0] addr_q, addr_d;
  logic evt_tgl_q, evt_tgl_d, mode_lnk_q;

  // Data is taken on the rising clock edge in both modes 0 and 3.
  wire logic [7:0] byte_in = {shift_q[6:0], spi_si_i}; // RULE5
  wire logic byte_done = (bit_cnt_q == 3'h7);
  wire sfcf_pkg::sfcf_addr_cls_t in_cls = sfcf_cls(byte_in);
  wire sfcf_pkg::sfcf_addr_cls_t opc_cls = sfcf_cls(opc_q);
  wire logic [2:0] opc_dummy = (opc_q == `SFCF_OPC_DUMMY4) ? `SFCF_DUMMY4_CNT :
    (opc_q == `SFCF_OPC_DUMMY1_A || opc_q == `SFCF_OPC_DUMMY1_B) ?
    `SFCF_DUMMY1_CNT : 3'h0; // RULE4

  // Next-state logic of the frame walker.
  always_comb begin
    lnk_state_d = lnk_state_q;
    byte_cnt_d = byte_cnt_q;
    dum_cnt_d = dum_cnt_q;
    opc_d = opc_q;
    addr_d = addr_q;
    evt_tgl_d = evt_tgl_q;
    if (byte_done) begin
      case (lnk_state_q)
        sfcf_pkg::SFCF_LNK_OPC: begin
          opc_d = byte_in;
          byte_cnt_d = 2'h0;
          if (in_cls == sfcf_pkg::SFCF_ACLS_NONE) begin
            lnk_state_d = sfcf_pkg::SFCF_LNK_DATA;
            evt_tgl_d = ~evt_tgl_q;
          end else begin
            lnk_state_d = sfcf_pkg::SFCF_LNK_ADDR; // RULE5
          end
        end
        sfcf_pkg::SFCF_LNK_ADDR: begin
          addr_d = {addr_q[15:0], byte_in};
          byte_cnt_d = byte_cnt_q + 2'h1;
          if (byte_cnt_q == 2'(`SFCF_ADDR_BYTES - 1)) begin
            dum_cnt_d = opc_dummy;
            if (opc_dummy == 3'h0) begin
              lnk_state_d = sfcf_pkg::SFCF_LNK_DATA;
              evt_tgl_d = ~evt_tgl_q;
            end else begin
              lnk_state_d = sfcf_pkg::SFCF_LNK_DUMMY; // RULE4
            end
          end
        end
        sfcf_pkg::SFCF_LNK_DUMMY: begin
          dum_cnt_d = dum_cnt_q - 3'h1;
          if (dum_cnt_q == 3'h1) begin
            lnk_state_d = sfcf_pkg::SFCF_LNK_DATA;
            evt_tgl_d = ~evt_tgl_q;
          end
        end
        default: lnk_state_d = sfcf_pkg::SFCF_LNK_DATA;
      endcase
    end
  end

  // Frame registers; cleared while select is high, unlike the opcode, address and event toggle.
  always_ff @(posedge spi_sck_i or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      lnk_state_q <= sfcf_pkg::SFCF_LNK_OPC;
      bit_cnt_q <= 3'h0;
      byte_cnt_q <= 2'h0;
      dum_cnt_q <= 3'h0;
      shift_q <= 8'h00;
    end else begin
      lnk_state_q <= lnk_state_d;
      bit_cnt_q <= bit_cnt_q + 3'h1;
      byte_cnt_q <= byte_cnt_d;
      dum_cnt_q <= dum_cnt_d;
      shift_q <= byte_in;
    end
  end

  // Captured fields stay put after the frame so the core side can read them late.
  always_ff @(posedge spi_sck_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      opc_q <= 8'h00;
      addr_q <= 24'h000000;
      evt_tgl_q <= 1'b0;
    end else if (!spi_cs_n_i) begin
      opc_q <= opc_d;
      addr_q <= addr_d;
      evt_tgl_q <= evt_tgl_d;
    end
  end

  // The idle clock level is caught on the select fall itself; clocking may start at once.
  always_ff @(negedge spi_cs_n_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_lnk_q <= 1'b0;
    end else begin
      mode_lnk_q <= spi_sck_i; // RULE8
    end
  end

  // Field split by opcode class.
  wire logic [10:0] page_full = addr_q[`SFCF_PAGE_MSB:`SFCF_PAGE_LSB]; // RULE1
  wire logic [10:0] page_sel = (opc_cls == sfcf_pkg::SFCF_ACLS_PAGE_BYTE ||
    opc_cls == sfcf_pkg::SFCF_ACLS_PAGE) ? page_full :
    (opc_cls == sfcf_pkg::SFCF_ACLS_PAGE_HI) ? {page_full[10:3], 3'h0} : 11'h000; // RULE2
  wire logic [8:0] byte_sel = (opc_cls == sfcf_pkg::SFCF_ACLS_PAGE_BYTE ||
    opc_cls == sfcf_pkg::SFCF_ACLS_BYTE) ? addr_q[`SFCF_BYTE_MSB:0] : 9'h000; // RULE1
  wire logic is_rmw = (opc_q == `SFCF_OPC_RMW_A) || (opc_q == `SFCF_OPC_RMW_B); // RULE3
  wire sfcf_pkg::sfcf_cmd_t lnk_cmd = '{opcode: opc_q, addr_cls: opc_cls,
    page_addr_bit: page_sel, byte_addr: byte_sel, rmw: is_rmw, dummy_bytes: opc_dummy};

  // ****************************************************************
  // Core domain: synchronisers
  // ****************************************************************
  logic cs_s1_q, cs_s2_q, cs_prev_q;
  logic mode_s1_q, mode_s2_q;
  logic tgl_s1_q, tgl_s2_q, tgl_prev_q;

  // First stages feed only the second stages.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_prev_q <= 1'b1;
      mode_s1_q <= 1'b0;
      mode_s2_q <= 1'b0;
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_prev_q <= 1'b0;
    end else begin
      cs_s1_q <= spi_cs_n_i;
      cs_s2_q <= cs_s1_q;
      cs_prev_q <= cs_s2_q;
      mode_s1_q <= mode_lnk_q;
      mode_s2_q <= mode_s1_q;
      tgl_s1_q <= evt_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_prev_q <= tgl_s2_q;
    end
  end

  wire logic cs_fall = cs_prev_q & ~cs_s2_q;
  wire logic frame_evt = tgl_s2_q ^ tgl_prev_q;

  // ****************************************************************
  // Core domain: power-up sequencing and command hand-off
  // ****************************************************************
  logic [23:0] puw_cnt_q;
  sfcf_pkg::sfcf_pwr_state_t pwr_q, pwr_d;
  logic armed_q;
  logic mode3_q, so_q, so_oe_q;
  logic cmd_valid_q;
  sfcf_pkg::sfcf_cmd_t cmd_q;

  wire logic puw_done = (puw_cnt_q == 24'(PUW_CYCLES - 1));
  wire logic ready = (pwr_q != sfcf_pkg::SFCF_PWR_RESET);
  wire logic take_cmd = frame_evt & armed_q; // RULE10

  // Power state follows select once the delay has run out.
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      sfcf_pkg::SFCF_PWR_RESET: begin
        if (puw_done) begin
          pwr_d = cs_s2_q ? sfcf_pkg::SFCF_PWR_STANDBY : sfcf_pkg::SFCF_PWR_ACTIVE; // RULE12
        end
      end
      default: pwr_d = cs_s2_q ? sfcf_pkg::SFCF_PWR_STANDBY : sfcf_pkg::SFCF_PWR_ACTIVE;
    endcase
  end

  // The delay counter holds at its end value once the device is out of reset.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      puw_cnt_q <= 24'h000000;
      pwr_q <= sfcf_pkg::SFCF_PWR_RESET;
    end else begin
      puw_cnt_q <= (ready || puw_done) ? puw_cnt_q : puw_cnt_q + 24'h000001;
      pwr_q <= pwr_d;
    end
  end

  // A select fall after the delay arms the decoder; a frame begun earlier is dropped.
  // The mode is copied while select is low, so a late-settling sync stage costs one cycle.
  // Read data is outside this block, so the output pin is never enabled here.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      armed_q <= 1'b0;
      mode3_q <= 1'b0;
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      armed_q <= armed_q | (cs_fall & ready); // RULE7
      mode3_q <= cs_s2_q ? mode3_q : mode_s2_q; // RULE8
      so_q <= 1'b0;
      so_oe_q <= 1'b0; // RULE6
    end
  end

  // The fields are stable in the link domain well before the synchronised toggle arrives.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_valid_q <= 1'b0;
      cmd_q <= '0;
    end else begin
      cmd_valid_q <= take_cmd;
      cmd_q <= take_cmd ? lnk_cmd : cmd_q;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign spi_so_o = so_q;
  assign spi_so_oe_o = so_oe_q;
  assign cmd_valid_o = cmd_valid_q;
  assign cmd_o = cmd_q;
  assign spi_mode3_o = mode3_q;
  assign pwr_state_o = pwr_q;

endmodule : sfcf_top

/* tb/sfcf_top_monitor.sv */
// Concurrent checks on the ports of the command-frame decoder.
// Assumes the core clock; select is sampled as a plain level with a short sync lag.
`timescale 1ns/100ps
module sfcf_top_monitor (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Serial link.
  input wire logic spi_sck_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_si_i,
  // Outputs under check.
  input wire logic spi_so_o,
  input wire logic spi_so_oe_o,
  input wire logic cmd_valid_o,
  input sfcf_pkg::sfcf_cmd_t cmd_o,
  input wire logic spi_mode3_o,
  input sfcf_pkg::sfcf_pwr_state_t pwr_state_o
);
  // ******
  // Properties
  // ******
  // Select crosses a synchroniser, so levels are judged only after several stable cycles.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_cs_high; spi_cs_n_i [*5]; endsequence
  sequence s_cs_low; !spi_cs_n_i [*7]; endsequence
  sequence s_ready; pwr_state_o != sfcf_pkg::SFCF_PWR_RESET; endsequence
  a_out_hiz: assert property (!spi_so_oe_o)
    else $error("data output enabled");
  a_valid_pulse: assert property (cmd_valid_o |=> !cmd_valid_o)
    else $error("valid longer than one cycle");
  a_por_silent: assert property (pwr_state_o == sfcf_pkg::SFCF_PWR_RESET |-> !cmd_valid_o)
    else $error("command during power-up delay");
  a_rmw_flag: assert property (cmd_valid_o |->
    cmd_o.rmw == (cmd_o.opcode inside {8'h58, 8'h59}))
    else $error("read-modify-write flag wrong");
  a_dummy_count: assert property (cmd_valid_o |-> cmd_o.dummy_bytes ==
    ((cmd_o.opcode == 8'hD2) ? 3'h4 : (cmd_o.opcode inside {8'hD4, 8'hD6}) ? 3'h1 : 3'h0))
    else $error("dummy byte count wrong");
  a_unused_zero: assert property (cmd_valid_o && cmd_o.addr_cls inside
    {sfcf_pkg::SFCF_ACLS_NONE, sfcf_pkg::SFCF_ACLS_DUMMY} |->
    cmd_o.page_addr_bit == 11'h0 && cmd_o.byte_addr == 9'h0)
    else $error("dummy bits leaked into fields");
  a_page_only: assert property (cmd_valid_o && cmd_o.addr_cls inside
    {sfcf_pkg::SFCF_ACLS_PAGE, sfcf_pkg::SFCF_ACLS_PAGE_HI} |-> cmd_o.byte_addr == 9'h0)
    else $error("byte field set for page command");
  a_go_standby: assert property (s_ready ##0 s_cs_high |->
    pwr_state_o == sfcf_pkg::SFCF_PWR_STANDBY)
    else $error("not in standby with select high");
  a_go_active: assert property (s_ready ##0 s_cs_low |->
    pwr_state_o == sfcf_pkg::SFCF_PWR_ACTIVE)
    else $error("not active with select low");
  a_mode_steady: assert property (s_cs_low |-> $stable(spi_mode3_o))
    else $error("mode changed inside a frame");
endmodule : sfcf_top_monitor

bind sfcf_top sfcf_top_monitor i_sfcf_top_monitor (.core_clk_i, .reset_n_i, .spi_sck_i,
  .spi_cs_n_i, .spi_si_i, .spi_so_o, .spi_so_oe_o, .cmd_valid_o, .cmd_o, .spi_mode3_o,
  .pwr_state_o);

/* tb/sfcf_host_model.sv */
// Behavioural host that drives select, serial clock and serial input.
// Assumes a 6 ns link clock that runs only inside frames.
`timescale 1ns/100ps
module sfcf_host_model (
  // Serial link towards the device.
  output logic spi_sck_o,
  output logic spi_cs_n_o,
  output logic spi_si_o
);
  // Deselected and still at start.
  initial begin
    spi_sck_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_si_o = 1'b0;
  end
  // Drives select directly, for reset scenarios.
  task automatic select(input logic v);
    spi_cs_n_o <= v;
  endtask : select
  // Sends n bits from the top of bits; the released data line shows the inverse bit.
  task automatic frame(input logic [79:0] bits, input int n, input logic mode3);
    spi_sck_o = mode3;
    #4 spi_cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      #3 spi_sck_o = 1'b0;
      spi_si_o = bits[79-i];
      #3 spi_sck_o = 1'b1;
    end
    #3 spi_sck_o = mode3;
    #20 spi_cs_n_o = 1'b1;
    spi_si_o = ~spi_si_o;
    #60;
  endtask : frame
endmodule : sfcf_host_model

/* tb/tb_top.sv */
// Self-checking bench of the command-frame decoder with a host model.
// Assumes a shortened power-up delay of 50 core cycles.
`timescale 1ns/100ps
module tb_top;
  localparam int PUW = 50;
  localparam int READ_WAIT = 7000; // Host wait before reads, 70 us.
  typedef struct {logic [7:0] opc; logic [2:0] cls; logic rmw; logic [2:0] dum;} sfcf_row_t;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b1;
  logic sck, cs_n, si, so, so_oe, cmd_valid, mode3;
  sfcf_pkg::sfcf_cmd_t cmd, got;
  sfcf_pkg::sfcf_pwr_state_t pwr;
  int n_fail = 0;
  int n_tests = 0;
  int n_valid = 0;
  int cyc = 0;
  sfcf_row_t rows [12] = '{'{8'h82, 3'h1, 1'h0, 3'h0}, '{8'h58, 3'h1, 1'h1, 3'h0},
    '{8'h59, 3'h1, 1'h1, 3'h0}, '{8'hD2, 3'h1, 1'h0, 3'h4}, '{8'hD4, 3'h4, 1'h0, 3'h1},
    '{8'hD6, 3'h4, 1'h0, 3'h1}, '{8'h50, 3'h3, 1'h0, 3'h0}, '{8'h53, 3'h2, 1'h0, 3'h0},
    '{8'h84, 3'h4, 1'h0, 3'h0}, '{8'h77, 3'h5, 1'h0, 3'h0}, '{8'h9F, 3'h0, 1'h0, 3'h0},
    '{8'h03, 3'h1, 1'h0, 3'h0}};

  sfcf_host_model i_sfcf_host_model (.spi_sck_o(sck), .spi_cs_n_o(cs_n), .spi_si_o(si));
  sfcf_top #(.PUW_CYCLES(PUW)) i_sfcf_top (.core_clk_i, .reset_n_i, .spi_sck_i(sck),
    .spi_cs_n_i(cs_n), .spi_si_i(si), .spi_so_o(so), .spi_so_oe_o(so_oe),
    .cmd_valid_o(cmd_valid), .cmd_o(cmd), .spi_mode3_o(mode3), .pwr_state_o(pwr));

  // ******
  // Clock, capture and timeout
  // ******
  always #5 core_clk_i = ~core_clk_i;
  // Each pulse is counted, so refused frames show up as a missing increment.
  always @(posedge core_clk_i) begin
    if (cmd_valid === 1'b1) begin
      n_valid++;
      got = cmd;
    end
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    if (n_fail == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // Page and byte fields kept by each address class; the rest reads as zero.
  function automatic logic [19:0] fields(input logic [2:0] c, input logic [23:0] a);
    fields = 20'h0;
    if (c == 3'h1 || c == 3'h2) fields[19:9] = a[19:9];
    if (c == 3'h3) fields[19:9] = {a[19:12], 3'h0};
    if (c == 3'h1 || c == 3'h4) fields[8:0] = a[8:0];
  endfunction : fields

  // ******
  // Main sequence
  // ******
  initial begin
    int k;
    logic [23:0] a;
    // A real falling edge, so the asynchronous resets fire at the start.
    reset_n_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    chk(so_oe, 24'h0);
    reset_n_i <= 1'b1;
    // A frame inside the power-up delay must be ignored.
    k = n_valid;
    i_sfcf_host_model.frame({8'h82, 72'h0}, 40, 1'b0);
    chk(24'(n_valid - k), 24'h0);
    chk(pwr, sfcf_pkg::SFCF_PWR_RESET);
    repeat (PUW) @(posedge core_clk_i);
    chk(pwr, sfcf_pkg::SFCF_PWR_STANDBY);
    repeat (READ_WAIT) @(posedge core_clk_i);
    // Table of opcodes, alternating mode 0 and mode 3, with one data byte after the header.
    foreach (rows[i]) begin
      a = 24'hF5A5C3 + 24'(i * 24'h13B57);
      k = n_valid;
      i_sfcf_host_model.frame({rows[i].opc, a, 48'h5AA55AA55AA5},
        16 + (rows[i].cls != 3'h0 ? 24 : 0) + 8 * rows[i].dum, i[0]);
      repeat (4) @(posedge core_clk_i);
      chk(24'(n_valid - k), 24'h1);
      chk(got.opcode, rows[i].opc);
      chk(got.addr_cls, rows[i].cls);
      chk({got.page_addr_bit, got.byte_addr}, fields(rows[i].cls, a));
      chk(got.rmw, rows[i].rmw);
      chk(got.dummy_bytes, rows[i].dum);
      chk(mode3, i[0]);
    end
    // Frames cut short in the address and before the last dummy byte give nothing.
    for (int j = 0; j < 2; j++) begin
      k = n_valid;
      i_sfcf_host_model.frame(j ? {8'hD2, 72'h0} : {8'h82, 72'h0}, j ? 56 : 20, 1'b1);
      repeat (6) @(posedge core_clk_i);
      chk(24'(n_valid - k), 24'h0);
    end
    // Second reset with select low: the delay ends in active mode.
    reset_n_i <= 1'b0;
    i_sfcf_host_model.select(1'b0);
    repeat (2) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    repeat (PUW + 10) @(posedge core_clk_i);
    chk(pwr, sfcf_pkg::SFCF_PWR_ACTIVE);
    chk(so_oe, 24'h0);
    // Select low since reset: a frame without a fresh fall must be refused.
    k = n_valid;
    i_sfcf_host_model.frame({8'h9F, 72'h0}, 8, 1'b0);
    repeat (4) @(posedge core_clk_i);
    chk(24'(n_valid - k), 24'h0);
    i_sfcf_host_model.select(1'b1);
    repeat (10) @(posedge core_clk_i);
    k = n_valid;
    i_sfcf_host_model.frame({8'h9F, 72'h0}, 8, 1'b0);
    repeat (4) @(posedge core_clk_i);
    chk(24'(n_valid - k), 24'h1);
    end_of_test();
  end
endmodule : tb_top
